// ==== eeprom_map_pkg.sv ====
package eeprom_map_pkg;
  localparam int SECTORS          = 64;
  localparam int BLOCKS_PER_SEC   = 32;
  localparam int BLOCK_BITS       = 32;
  localparam int BYTES_PER_SEC    = 128;
  localparam int NUM_BLOCKS       = SECTORS * BLOCKS_PER_SEC;
  localparam int BYTE_ADDR_W      = 13;
  localparam int BLOCK_ADDR_W     = 11;
  localparam int SECTOR_W         = 6;
  localparam int SEC_MSB          = 12;
  localparam int SEC_LSB          = 7;
  localparam int SEL_HIDDEN_BIT   = 3;
  localparam int SAB_LOCK_BIT     = 0;
  localparam int SAB_RW_LSB       = 1;
  localparam int SAB_RW_MSB       = 2;
  localparam int UID_BITS         = 64;
  localparam int FAMILY_BITS      = 8;
  localparam int NUM_PASSWORDS    = 4;
  localparam logic [7:0] SAB_RESET = 8'h00;
  localparam logic [7:0] SAB_USED_MASK = 8'h1F;
  localparam logic [1:0] RW_OPEN       = 2'h0;
  localparam logic [1:0] RW_WRITE_LOCK = 2'h1;
  localparam logic [1:0] RW_READ_LOCK  = 2'h2;
  localparam logic [1:0] RW_ALL_LOCK   = 2'h3;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  select;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } byte_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [10:0] addr;
    logic [31:0] wdata;
  } block_req_t;

  typedef struct packed {
    logic        done;
    logic        denied;
    logic [31:0] rdata;
  } resp_t;
endpackage

// ==== eeprom_sector_map.sv ====
// Functional notes
// RULE1: Array is 64 sectors of 32 words.
// RULE2: Access only if sector protection allows it.
// RULE3: Hidden 64-bit identifier, not user-accessible.
// RULE4: Two 8-bit family identifier registers kept.
// RULE5: Four 32-bit password blocks kept separately.
// RULE6: Contactless accesses whole words, sector-wide rights.
// RULE7: Contactless write replaces whole 32-bit word.
// RULE8: Two-wire sees 128 bytes per sector.
// RULE9: Two-wire write-lock rejects writes to sector.
// RULE10: Master sends hidden enable bit zero.
// RULE11: Select bit three picks user array.
// RULE12: Access byte: lock, rw bits, password bits.
// RULE13: Access bytes reset to zero.
// RULE14: Word n equals byte 4n; sector bits.
// RULE15: Check protection first; denied leaves data; a collision-denied two-wire write is stored if the contactless one is denied.
`timescale 1ns/1ns
module eeprom_sector_map
  import eeprom_map_pkg::*;
#(
  parameter int NSEC = SECTORS
) (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  eeprom_map_pkg::byte_req_t       tw_req_i,
  input  eeprom_map_pkg::block_req_t      rf_req_i,
  input  wire logic                       sab_we_i,
  input  wire logic [5:0]                 sab_sel_i,
  input  wire logic [7:0]                 sab_wdata_i,
  input  wire logic [5:0]                 tw_lock_sel_i,
  input  wire logic                       tw_lock_val_i,
  input  wire logic                       tw_lock_we_i,
  input  wire logic                       sys_we_i,
  input  wire logic [2:0]                 sys_sel_i,
  input  wire logic [31:0]                sys_wdata_i,
  output eeprom_map_pkg::resp_t           tw_resp_o,
  output eeprom_map_pkg::resp_t           rf_resp_o,
  output logic [7:0]                      sab_rdata_o,
  output logic [63:0]                     uid_o,
  output logic [7:0]                      app_family_o,
  output logic [7:0]                      dsf_family_o,
  output logic [31:0]                     tw_password_o
);
  import eeprom_map_pkg::*;

  localparam logic [2:0] SYS_AFI = 3'h0;
  localparam logic [2:0] SYS_DSF = 3'h1;
  localparam logic [2:0] SYS_PW0 = 3'h2;
  localparam logic [2:0] SYS_UIDL = 3'h6;
  localparam logic [2:0] SYS_UIDH = 3'h7;

  logic [31:0] mem [NUM_BLOCKS];                     // [RULE1]
  logic [7:0]  sab [NSEC];
  logic        tw_lock [NSEC];
  logic [31:0] pw [NUM_PASSWORDS];                   // [RULE5]
  logic [63:0] uid;
  logic [7:0]  afi;
  logic [7:0]  dsf;

  logic [5:0]  tw_sec;
  logic [5:0]  rf_sec;
  logic [10:0] tw_blk;
  logic [1:0]  tw_lane;
  logic        tw_user;
  logic        tw_rd_ok;
  logic        tw_wr_ok;
  logic        rf_rd_ok;
  logic        rf_wr_ok;

  function automatic logic rd_allowed(input logic [7:0] s);
    rd_allowed = !s[SAB_LOCK_BIT] || (s[SAB_RW_MSB:SAB_RW_LSB] != RW_READ_LOCK
                 && s[SAB_RW_MSB:SAB_RW_LSB] != RW_ALL_LOCK);  // [RULE12]
  endfunction

  // A read-only lock must leave writes open, so each direction is judged alone
  function automatic logic wr_allowed(input logic [7:0] s);
    wr_allowed = !s[SAB_LOCK_BIT] || (s[SAB_RW_MSB:SAB_RW_LSB] != RW_WRITE_LOCK
                 && s[SAB_RW_MSB:SAB_RW_LSB] != RW_ALL_LOCK);  // [RULE2] [RULE12]
  endfunction

  always_comb begin
    tw_sec   = tw_req_i.addr[SEC_MSB:SEC_LSB];       // [RULE14]
    tw_blk   = tw_req_i.addr[12:2];                  // [RULE14]
    tw_lane  = tw_req_i.addr[1:0];                   // [RULE8]
    tw_user  = !tw_req_i.select[SEL_HIDDEN_BIT];     // [RULE10] [RULE11]
    rf_sec   = rf_req_i.addr[10:5];                  // [RULE6]
    tw_rd_ok = tw_user && rd_allowed(sab[tw_sec]);   // [RULE2]
    tw_wr_ok = tw_user && wr_allowed(sab[tw_sec]) && !tw_lock[tw_sec];  // [RULE9] [RULE15]
    rf_rd_ok = rd_allowed(sab[rf_sec]);              // [RULE2] [RULE6]
    rf_wr_ok = wr_allowed(sab[rf_sec]);              // [RULE15]
  end

  // Protection state; lost on reset since this model holds no real cells
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NSEC; i++) begin
        sab[i]     <= SAB_RESET;                     // [RULE13]
        tw_lock[i] <= 1'b0;
      end
    end else begin
      if (sab_we_i)
        sab[sab_sel_i] <= sab_wdata_i & SAB_USED_MASK;  // [RULE12]
      if (tw_lock_we_i)
        tw_lock[tw_lock_sel_i] <= tw_lock_val_i;
    end
  end

  // System area: identifier only loaded through the production port
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      uid <= 64'h0;
      afi <= 8'h00;
      dsf <= 8'h00;
      for (int i = 0; i < NUM_PASSWORDS; i++)
        pw[i] <= 32'h0;
    end else if (sys_we_i) begin
      case (sys_sel_i)
        SYS_AFI:  afi <= sys_wdata_i[7:0];           // [RULE4]
        SYS_DSF:  dsf <= sys_wdata_i[7:0];           // [RULE4]
        SYS_UIDL: uid[31:0] <= sys_wdata_i;          // [RULE3]
        SYS_UIDH: uid[63:32] <= sys_wdata_i;         // [RULE3]
        default:  pw[2'(sys_sel_i - SYS_PW0)] <= sys_wdata_i;  // [RULE5]
      endcase
    end
  end

  // Array storage; no reset, contents are nonvolatile
  always_ff @(posedge clk_i) begin
    if (rf_req_i.valid && rf_req_i.write && rf_wr_ok)
      mem[rf_req_i.addr] <= rf_req_i.wdata;          // [RULE7]
    else if (tw_req_i.valid && tw_req_i.write && tw_wr_ok)
      mem[tw_blk][tw_lane*8 +: 8] <= tw_req_i.wdata; // [RULE8] [RULE15]
  end

  // Contactless has priority; a colliding two-wire write is reported denied
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tw_resp_o <= '0;
      rf_resp_o <= '0;
    end else begin
      rf_resp_o.done   <= rf_req_i.valid;
      rf_resp_o.denied <= rf_req_i.valid && !(rf_req_i.write ? rf_wr_ok : rf_rd_ok);
      rf_resp_o.rdata  <= (rf_req_i.valid && !rf_req_i.write && rf_rd_ok) ? mem[rf_req_i.addr] : 32'h0;
      tw_resp_o.done   <= tw_req_i.valid;
      tw_resp_o.denied <= tw_req_i.valid && (tw_req_i.write
                          ? (!tw_wr_ok || (rf_req_i.valid && rf_req_i.write)) : !tw_rd_ok);
      tw_resp_o.rdata  <= (tw_req_i.valid && !tw_req_i.write && tw_rd_ok)
                          ? {24'h0, mem[tw_blk][tw_lane*8 +: 8]} : 32'h0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sab_rdata_o   <= 8'h00;
      uid_o         <= 64'h0;
      app_family_o  <= 8'h00;
      dsf_family_o  <= 8'h00;
      tw_password_o <= 32'h0;
    end else begin
      sab_rdata_o   <= sab[sab_sel_i];
      uid_o         <= uid;                          // [RULE3]
      app_family_o  <= afi;
      dsf_family_o  <= dsf;
      tw_password_o <= pw[0];
    end
  end

  // Data checks only hold for cells written earlier; untouched cells stay unknown
  a_tw_lock_deny: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE9]
    tw_req_i.valid && tw_req_i.write && tw_lock[tw_sec] |=> tw_resp_o.denied)
    else $error("locked two-wire write not denied");
  a_sab_reset_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE13]
    $fell(sys_rst_i) |-> sab[0] == 8'h00)
    else $error("access byte not zero after reset");
  a_rf_write_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE15]
    rf_req_i.valid && rf_req_i.write && !rf_wr_ok && !tw_req_i.valid
    |=> mem[$past(rf_req_i.addr)] == $past(mem[rf_req_i.addr]))
    else $error("denied write changed data");
  a_rf_write_full: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE7]
    rf_req_i.valid && rf_req_i.write && rf_wr_ok |=> mem[$past(rf_req_i.addr)] == $past(rf_req_i.wdata))
    else $error("contactless write not whole word");
  a_hidden_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE11]
    tw_req_i.valid && tw_req_i.select[SEL_HIDDEN_BIT] |=> tw_resp_o.denied)
    else $error("system select reached user array");
  a_rf_read_deny: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE2]
    rf_req_i.valid && !rf_req_i.write && !rf_rd_ok |=> rf_resp_o.denied && rf_resp_o.rdata == 32'h0)
    else $error("protected read leaked data");
  a_done_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE6]
    rf_req_i.valid |=> rf_resp_o.done)
    else $error("contactless answer missing");
  a_sab_top_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE12]
    sab_rdata_o[7:5] == 3'h0)
    else $error("access byte top bits set");
  a_tw_done_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE8]
    tw_req_i.valid |=> tw_resp_o.done)
    else $error("two-wire answer missing");
  a_rf_done_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE6]
    !rf_req_i.valid |=> !rf_resp_o.done)
    else $error("contactless answer without request");
  a_tw_write_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE8]
    tw_req_i.valid && tw_req_i.write && tw_wr_ok && !(rf_req_i.valid && rf_req_i.write)
    |=> mem[$past(tw_blk)][$past(tw_lane)*8 +: 8] == $past(tw_req_i.wdata))
    else $error("two-wire byte not written");
  a_tw_deny_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE15]
    tw_req_i.valid && tw_req_i.write && !tw_wr_ok && !(rf_req_i.valid && rf_req_i.write)
    |=> mem[$past(tw_blk)] == $past(mem[tw_blk]))
    else $error("denied two-wire write changed data");
  a_read_only_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE2]
    rf_req_i.valid && rf_req_i.write && sab[rf_sec][SAB_LOCK_BIT]
    && sab[rf_sec][SAB_RW_MSB:SAB_RW_LSB] == RW_READ_LOCK |=> !rf_resp_o.denied)
    else $error("read lock blocked a write");
  a_collide_deny: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE15]
    rf_req_i.valid && rf_req_i.write && tw_req_i.valid && tw_req_i.write |=> tw_resp_o.denied)
    else $error("colliding two-wire write not denied");
  a_tw_read_deny: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE2]
    tw_req_i.valid && !tw_req_i.write && !tw_rd_ok |=> tw_resp_o.denied && tw_resp_o.rdata == 32'h0)
    else $error("protected byte read leaked data");
  a_lock_latch: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE9]
    tw_lock_we_i |=> tw_lock[$past(tw_lock_sel_i)] == $past(tw_lock_val_i))
    else $error("write lock not stored");
  a_sab_write_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE12]
    sab_we_i |=> sab[$past(sab_sel_i)] == ($past(sab_wdata_i) & SAB_USED_MASK))
    else $error("access byte not stored masked");
  a_rf_read_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE6]
    rf_req_i.valid && !rf_req_i.write && rf_rd_ok
    |=> !rf_resp_o.denied && rf_resp_o.rdata == $past(mem[rf_req_i.addr]))
    else $error("contactless read data wrong");
  a_tw_read_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)  // [RULE14]
    tw_req_i.valid && !tw_req_i.write && tw_rd_ok
    |=> !tw_resp_o.denied && tw_resp_o.rdata == {24'h0, $past(mem[tw_blk][tw_lane*8 +: 8])})
    else $error("two-wire read data wrong");
endmodule // eeprom_sector_map

// ==== access_master.sv ====
`timescale 1ns/1ns
module access_master
  import eeprom_map_pkg::*;
(
  input  wire logic                  clk_i,
  input  eeprom_map_pkg::resp_t      tw_resp_i,
  input  eeprom_map_pkg::resp_t      rf_resp_i,
  output eeprom_map_pkg::byte_req_t  tw_req_o,
  output eeprom_map_pkg::block_req_t rf_req_o
);
  initial begin
    tw_req_o = '0;
    rf_req_o = '0;
  end
  // Idle fields flip so stale values never look valid
  task automatic tw_op(input logic w, input logic hid, input logic [12:0] a, input logic [7:0] d, output resp_t r);
    @(posedge clk_i);
    tw_req_o <= '{1'b1, w, {4'hA, hid, 2'h0, ~w}, a, d};
    @(posedge clk_i);
    tw_req_o <= {1'b0, ~tw_req_o[29:0]};
    #1 r = tw_resp_i;
  endtask
  task automatic rf_op(input logic w, input logic [10:0] n, input logic [31:0] d, output resp_t r);
    @(posedge clk_i);
    rf_req_o <= '{1'b1, w, n, d};
    @(posedge clk_i);
    rf_req_o <= {1'b0, ~rf_req_o[43:0]};
    #1 r = rf_resp_i;
  endtask
endmodule // access_master

// ==== dual_port_eeprom_sector_map_bench.sv ====
`timescale 1ns/1ns
module dual_port_eeprom_sector_map_bench;
  import eeprom_map_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, sab_we_i = 0, tw_lock_we_i = 0, tw_lock_val_i = 0, sys_we_i = 0;
  logic [5:0]  sab_sel_i = 0, tw_lock_sel_i = 0;
  logic [7:0]  sab_wdata_i = 0, sab_rdata_o, app_family_o, dsf_family_o;
  logic [2:0]  sys_sel_i = 0;
  logic [31:0] sys_wdata_i = 0, tw_password_o, d;
  logic [63:0] uid_o;
  byte_req_t   tw_req_i;
  block_req_t  rf_req_i;
  resp_t       tw_resp_o, rf_resp_o;
  logic [7:0]  mem [int];
  logic [7:0]  sabm [64] = '{default: 8'h00};
  logic        lk [64] = '{default: 1'b0};
  logic [31:0] sysm [8];
  int          failures = 0, n_checks = 0, n, s;
  always #50 clk_i = ~clk_i;
  eeprom_sector_map u_eeprom_sector_map (.clk_i, .sys_rst_i, .tw_req_i, .rf_req_i, .sab_we_i, .sab_sel_i,
    .sab_wdata_i, .tw_lock_sel_i, .tw_lock_val_i, .tw_lock_we_i, .sys_we_i, .sys_sel_i, .sys_wdata_i,
    .tw_resp_o, .rf_resp_o, .sab_rdata_o, .uid_o, .app_family_o, .dsf_family_o, .tw_password_o);
  access_master u_access_master (.clk_i, .tw_resp_i(tw_resp_o), .rf_resp_i(rf_resp_o),
    .tw_req_o(tw_req_i), .rf_req_o(rf_req_i));
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tw(input logic w, input logic hid, input logic col, input int a, input logic [7:0] v);
    logic den;
    resp_t r;
    den = hid | col | (w ? (sabm[a>>7][0] & sabm[a>>7][1]) | lk[a>>7] : sabm[a>>7][0] & sabm[a>>7][2]);
    u_access_master.tw_op(w, hid, a[12:0], v, r);
    if (w && !den) mem[a] = v;
    chk(r, {1'b1, den, (w | den) ? 32'h0 : {24'h0, mem[a]}});
  endtask
  task automatic rf(input logic w, input int b, input logic [31:0] v);
    logic den;
    resp_t r;
    den = sabm[b>>5][0] & (w ? sabm[b>>5][1] : sabm[b>>5][2]);
    u_access_master.rf_op(w, b[10:0], v, r);
    if (w && !den) for (int k = 0; k < 4; k++) mem[4*b+k] = v[8*k+:8];
    chk(r, {1'b1, den, (w | den) ? 32'h0 : {mem[4*b+3], mem[4*b+2], mem[4*b+1], mem[4*b]}});
  endtask
  task automatic set_sab(input int t, input logic [7:0] v);
    @(posedge clk_i);
    sab_sel_i <= t[5:0];
    sab_wdata_i <= v;
    sab_we_i <= 1'b1;
    @(posedge clk_i);
    sab_we_i <= 1'b0;
    sabm[t] = v & 8'h1F;
    @(posedge clk_i);
    #1 chk(sab_rdata_o, sabm[t]);
  endtask
  task automatic set_lock(input int t, input logic v);
    @(posedge clk_i);
    tw_lock_sel_i <= t[5:0];
    tw_lock_val_i <= v;
    tw_lock_we_i <= 1'b1;
    @(posedge clk_i);
    tw_lock_we_i <= 1'b0;
    lk[t] = v;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hE7AA7861));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(sab_rdata_o, 8'h00);
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(2047);
      rf(1, n, $urandom);
      for (int k = 0; k < 4; k++) tw(0, 0, 0, 4*n+k, 0);
      tw(1, 0, 0, 4*n+1, $urandom);
      rf(0, n, 0);
    end
    s = $urandom_range(63);
    n = s*32 + 31;
    rf(1, n, $urandom);
    rf(1, s*32, $urandom);
    for (int i = 0; i < 8; i++) begin
      set_sab(s, 8'hE0 | i);
      rf(1, n, $urandom);
      rf(0, n, 0);
      tw(1, 0, 0, 4*s*32, $urandom);
      tw(0, 0, 0, 4*s*32, 0);
      tw(0, 0, 0, 4*n+3, 0);
    end
    set_sab(s, 8'h00);
    set_lock(s, 1);
    tw(1, 0, 0, s*128+127, $urandom);
    rf(1, n, $urandom);
    set_lock(s, 0);
    tw(1, 0, 0, s*128+127, $urandom);
    tw(0, 1, 0, 4*n, 0);
    tw(1, 1, 0, 4*n, $urandom);
    tw(0, 0, 0, 4*n, 0);
    fork
      rf(1, n, $urandom);
      tw(1, 0, 1, 4*n+2, 8'h5A);
    join
    rf(0, n, 0);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      @(posedge clk_i);
      sys_sel_i <= i[2:0];
      sys_wdata_i <= d;
      sys_we_i <= 1'b1;
      sysm[i] = d;
      @(posedge clk_i);
      sys_we_i <= 1'b0;
    end
    @(posedge clk_i);
    #1 chk(app_family_o, sysm[0][7:0]);
    chk(dsf_family_o, sysm[1][7:0]);
    chk(tw_password_o, sysm[2]);
    chk(uid_o, {sysm[7], sysm[6]});
    report_and_stop;
  end
endmodule // dual_port_eeprom_sector_map_bench
